// >>> gio_pkg.sv
// Package with register map, field layout, reset values and types of the GPIO port block.
package gio_pkg;

  // ==========================================================================
  // Sizes
  localparam int NPORT = 4;
  localparam int NPIN = 8;
  localparam int FLAG_W = 7;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] PORT_SPAN = 12'h080;
  localparam logic [4:0] OFS_OUT = 5'h00;
  localparam logic [4:0] OFS_IN = 5'h04;
  localparam logic [4:0] OFS_DIR = 5'h08;
  localparam logic [4:0] OFS_CFG = 5'h0c;
  localparam logic [4:0] OFS_CTL2 = 5'h10;
  localparam logic [11:0] OFS_DBG = 12'h100;
  localparam logic [11:0] OFS_TRIG = 12'h200;
  localparam logic [11:0] OFS_NMI = 12'h204;
  localparam logic [11:0] OFS_CLR = 12'h208;
  localparam logic [11:0] OFS_MASK = 12'h20c;

  // ==========================================================================
  // Field positions and reset values
  localparam int DBG_BIT = 0;
  localparam int NMI_SEL_BIT = 2;
  localparam int NMI_FLAG = 6;
  localparam logic [6:0] FLAG_BITS = 7'h4f;
  localparam logic [7:0] CFG_D_RST = 8'h02;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Trigger modes of a port
  typedef enum logic [1:0] {
    TRIG_FALL_LOW = 2'h0,
    TRIG_RISE = 2'h1,
    TRIG_FALL = 2'h2,
    TRIG_BOTH = 2'h3
  } gio_trig_type;

  // Drive of the eight pads of one port.
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
    logic [7:0] fast;
  } gio_pad_type;

  // Whole state of the block.
  typedef struct packed {
    logic [3:0][7:0] dout;
    logic [3:0][7:0] dir;
    logic [3:0][7:0] cfg;
    logic [3:0][7:0] ctl2;
    logic [3:0][7:0] sync1;
    logic [3:0][7:0] sync2;
    logic [3:0][7:0] sync3;
    logic [3:0][7:0] level;
    gio_pad_type [3:0] pad;
    logic [7:0] trig;
    logic nmi_sel;
    logic dbg_rel;
    logic [6:0] flag;
    logic [6:0] mask;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gio_state_type;

endpackage

// >>> gio_port.sv
// Four 8-pin GPIO ports with external interrupt flags, behind an AXI4-Lite slave.
//
// Behaviour
// RULE_01: Each port has eight output bits that drive a pin low or high in output mode.
// RULE_02: The filtered level of each pin is readable as a read-only input field.
// RULE_03: A direction bit puts a pin in input mode at 0 and output mode at 1, reset 0.
// RULE_04: A function bit selects floating/pull-up in input, open-drain/push-pull in output.
// RULE_05: In input mode a second bit disables or enables the pin's external interrupt.
// RULE_06: In output mode that second bit selects 2MHz at 0 or 10MHz at 1 drive speed.
// RULE_07: An enabled alternate function drives the pin instead of the output bit.
// RULE_08: After reset pins float, except port D pins 1 and 2 owned by debug, pin 1 pulled up.
// RULE_09: The debug release bit 0 keeps port D pins 1 and 2 for debug at 0, frees them at 1.
// RULE_10: An enabled input pin raises a request on the edge or low level of its trigger mode.
// RULE_11: Bit 2 of the second trigger register selects falling (0) or rising (1) non-maskable.
// RULE_12: The non-maskable trigger bit is written only while port C pin 3 interrupt is off.
// RULE_13: Writing one to clear bits 0 to 3 clears the port A to D flags, bit 6 the NMI flag.
// RULE_14: Software sets an analog pin to floating input with its interrupt off beforehand.
// RULE_15: Each port's trigger field selects 00 fall+low, 01 rise, 10 fall, 11 both edges.
// RULE_16: A port flag is set by a trigger on any enabled pin and stays until cleared.
// RULE_17: Reserved bits read as zero and ignore writes.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module gio_port
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // AXI4-Lite write channels.
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels.
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Package pins.
  input wire logic [3:0][7:0] pin_in,
  output gio_pkg::gio_pad_type [3:0] pad,
  // Alternate functions.
  input wire logic [3:0][7:0] alt_en,
  input wire logic [3:0][7:0] alt_out,
  // Serial debug on port D pins 1 and 2.
  input wire logic dbg_swdio_out,
  input wire logic dbg_swdio_oe,
  output logic dbg_swdio_in,
  output logic dbg_swclk_in,
  // Interrupts.
  input wire logic nmi_route,
  output logic [3:0] irq_port,
  output logic irq_nmi,
  output logic irq
);
  import gio_pkg::*;

  gio_state_type s;
  gio_state_type next_s;
  logic [3:0][7:0] lvl_n;
  logic [3:0][7:0] rise;
  logic [3:0][7:0] fall;
  logic [3:0][7:0] int_en;
  logic [7:0] en_p;
  logic port_c_pin3_en;
  logic [6:0] set;
  logic [6:0] clr;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_wr;
  logic wr_hit;
  logic [11:0] wa;
  logic [7:0] wd;
  logic ws;
  logic [32:0] rd_w;
  logic [32:0] wr_w;
  logic v;

  // ==========================================================================
  // Helpers

  // Decodes one address into {hit, read data}; reserved bits come back as zero.
  function automatic logic [32:0] reg_word(gio_state_type st, logic [11:0] a);
    logic [32:0] r;
    r = '0;
    if (a < PORT_SPAN)
    begin
      unique case (a[4:0])
        OFS_OUT: r = {1'b1, 24'h000000, st.dout[a[6:5]]};
        OFS_IN: r = {1'b1, 24'h000000, st.level[a[6:5]]};
        OFS_DIR: r = {1'b1, 24'h000000, st.dir[a[6:5]]};
        OFS_CFG: r = {1'b1, 24'h000000, st.cfg[a[6:5]]};
        OFS_CTL2: r = {1'b1, 24'h000000, st.ctl2[a[6:5]]};
        default: r = '0;
      endcase
    end
    else
    begin
      unique case (a)
        OFS_DBG: r = {1'b1, 31'h00000000, st.dbg_rel};
        OFS_TRIG: r = {1'b1, 24'h000000, st.trig};
        OFS_NMI: r = {1'b1, 29'h00000000, st.nmi_sel, 2'h0};
        OFS_CLR: r = {1'b1, 25'h0000000, st.flag};
        OFS_MASK: r = {1'b1, 25'h0000000, st.mask};
        default: r = '0;
      endcase
    end
    return r;
  endfunction

  // Tells whether any enabled pin of a port meets the selected trigger.
  function automatic logic trig_hit(gio_trig_type m, logic [7:0] en, logic [7:0] r,
                                    logic [7:0] f, logic [7:0] l);
    logic h;
    h = 1'b0;
    unique case (m)
      TRIG_FALL_LOW: h = |(en & (f | ~l));
      TRIG_RISE: h = |(en & r);
      TRIG_FALL: h = |(en & f);
      TRIG_BOTH: h = |(en & (r | f));
    endcase
    return h;
  endfunction

  // ==========================================================================
  // Bus handshakes

  // A channel is ready while nothing of its kind waits for an answer.
  assign awready = ~s.aw_got & ~s.bvalid;
  assign wready = ~s.w_got & ~s.bvalid;
  assign arready = ~s.rvalid;
  assign aw_hs = awvalid & awready;
  assign w_hs = wvalid & wready;
  assign ar_hs = arvalid & arready;

  // Address and data of the write may arrive in either order.
  assign wa = s.aw_got ? s.awaddr : awaddr;
  assign wd = s.w_got ? s.wdata : wdata[7:0];
  assign ws = s.w_got ? s.wstrb0 : wstrb[0];
  assign do_wr = (s.aw_got | aw_hs) & (s.w_got | w_hs) & ~s.bvalid;
  assign wr_w = reg_word(s, wa);
  assign wr_hit = wr_w[32];
  assign rd_w = reg_word(s, araddr);

  // ==========================================================================
  // Outputs from the state

  assign bresp = s.bresp;
  assign bvalid = s.bvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign rvalid = s.rvalid;
  assign pad = s.pad;
  assign dbg_swdio_in = s.level[3][1];
  assign dbg_swclk_in = s.level[3][2];
  assign irq_port = s.flag[3:0];
  assign irq_nmi = s.flag[NMI_FLAG];
  assign irq = |(s.flag & s.mask);

  // ==========================================================================
  // Next state

  // Computes input filtering, events, pad drive and register updates.
  always_comb
  begin
    next_s = s;
    clr = '0;
    set = '0;
    en_p = '0;
    v = 1'b0;
    // A level counts once the second and third stages agree.
    lvl_n = (s.sync2 & s.sync3) | (s.level & (s.sync2 | s.sync3)); // RULE_02
    rise = lvl_n & ~s.level;
    fall = s.level & ~lvl_n;
    int_en = ~s.dir & s.ctl2; // RULE_05
    port_c_pin3_en = int_en[2][3];
    next_s.sync1 = pin_in;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    next_s.level = lvl_n; // RULE_02

    // Port events; port C pin 3 feeds the non-maskable line when routed.
    for (int p = 0; p < NPORT; p++)
    begin
      en_p = int_en[p];
      if (p == 2 && nmi_route)
      begin
        en_p[3] = 1'b0;
      end
      set[p] = trig_hit(gio_trig_type'(s.trig[2*p +: 2]), en_p, rise[p], fall[p],
                        lvl_n[p]); // RULE_10 RULE_15
    end
    set[NMI_FLAG] = nmi_route & port_c_pin3_en & (s.nmi_sel ? rise[2][3] : fall[2][3]); // RULE_11

    // Pad drive, registered so the pins change right after the clock edge.
    for (int p = 0; p < NPORT; p++)
    begin
      for (int i = 0; i < NPIN; i++)
      begin
        v = alt_en[p][i] ? alt_out[p][i] : s.dout[p][i]; // RULE_07 RULE_01
        if (p == 3 && (i == 1 || i == 2) && !s.dbg_rel) // RULE_08 RULE_09
        begin
          next_s.pad[p].out[i] = (i == 1) ? dbg_swdio_out : 1'b0;
          next_s.pad[p].oe[i] = (i == 1) ? dbg_swdio_oe : 1'b0;
          next_s.pad[p].pull_up[i] = s.cfg[p][i];
          next_s.pad[p].fast[i] = 1'b0;
        end
        else if (s.dir[p][i]) // RULE_03
        begin
          // Open-drain only ever pulls low; push-pull drives both levels.
          next_s.pad[p].out[i] = s.cfg[p][i] & v; // RULE_04
          next_s.pad[p].oe[i] = s.cfg[p][i] | ~v; // RULE_04
          next_s.pad[p].pull_up[i] = 1'b0;
          next_s.pad[p].fast[i] = s.ctl2[p][i]; // RULE_06
        end
        else
        begin
          next_s.pad[p].out[i] = 1'b0;
          next_s.pad[p].oe[i] = 1'b0;
          next_s.pad[p].pull_up[i] = s.cfg[p][i]; // RULE_04
          next_s.pad[p].fast[i] = 1'b0;
        end
      end
    end

    // Write channel capture.
    if (aw_hs)
    begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (w_hs)
    begin
      next_s.w_got = 1'b1;
      next_s.wdata = wdata[7:0];
      next_s.wstrb0 = wstrb[0];
    end
    if (s.bvalid & bready)
    begin
      next_s.bvalid = 1'b0;
    end

    // Register write once both halves are present; only byte lane 0 holds fields.
    if (do_wr)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (ws && wa < PORT_SPAN)
      begin
        unique case (wa[4:0])
          OFS_OUT: next_s.dout[wa[6:5]] = wd; // RULE_01
          OFS_DIR: next_s.dir[wa[6:5]] = wd; // RULE_03
          OFS_CFG: next_s.cfg[wa[6:5]] = wd; // RULE_04
          OFS_CTL2: next_s.ctl2[wa[6:5]] = wd; // RULE_05 RULE_06
          default: next_s.dout = s.dout;
        endcase
      end
      else if (ws)
      begin
        unique case (wa)
          OFS_DBG: next_s.dbg_rel = wd[DBG_BIT]; // RULE_09
          OFS_TRIG: next_s.trig = wd; // RULE_15
          OFS_NMI:
          begin
            if (!int_en[2][3])
            begin
              next_s.nmi_sel = wd[NMI_SEL_BIT]; // RULE_11 RULE_12
            end
          end
          OFS_CLR: clr = wd[6:0] & FLAG_BITS; // RULE_13 RULE_17
          OFS_MASK: next_s.mask = wd[6:0] & FLAG_BITS; // RULE_17
          default: next_s.trig = s.trig;
        endcase
      end
    end

    // Flags are sticky, and a new event wins over a clear in the same cycle.
    next_s.flag = ((s.flag & ~clr) | set) & FLAG_BITS; // RULE_16 RULE_13

    // Read channel.
    if (s.rvalid & rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (ar_hs)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_w[31:0]; // RULE_17
      next_s.rresp = rd_w[32] ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ==========================================================================
  // State register

  // Synchronous reset; port D pin 1 comes up pulled up for the debugger.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      s <= '0;
      s.cfg[3] <= CFG_D_RST; // RULE_08
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Assertions

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // Push-pull output pin without alternate function follows its data bit.
  a_dout_drive: assert property (s.dir[0][0] && s.cfg[0][0] && !alt_en[0][0]
    |=> s.pad[0].out[0] == $past(s.dout[0][0]) && s.pad[0].oe[0]) // RULE_01
    else $error("push-pull pin does not follow output data");

  // The filtered level takes the third stage once two stages agree.
  a_level_filter: assert property (s.sync2[1][5] == s.sync3[1][5]
    |=> s.level[1][5] == $past(s.sync3[1][5])) // RULE_02
    else $error("input level did not follow agreed stages");

  // Direction is input everywhere in the first cycle after reset.
  a_dir_reset: assert property ($past(!nrst) |-> s.dir == '0 && s.cfg[3] == CFG_D_RST) // RULE_03
    else $error("direction or port D config wrong after reset");

  // Open-drain output never drives high.
  a_drain_low: assert property ($past(s.dir[0][0] & ~s.cfg[0][0]) && s.pad[0].oe[0]
    |-> !s.pad[0].out[0]) // RULE_04
    else $error("open-drain pin drove high");

  // Pull-up appears only for a pulled-up input pin or a pulled-up port D pin 1 or 2 owned by debug.
  a_pull_input: assert property (s.pad[2].pull_up[4]
    |-> $past(~s.dir[2][4] & s.cfg[2][4])) // RULE_04
    else $error("pull-up on a pin that is not a pulled-up input");

  // Fast drive only in output mode with the speed bit set.
  a_fast_out: assert property (s.pad[1].fast[6] == $past(s.dir[1][6] & s.ctl2[1][6])) // RULE_06
    else $error("speed selection wrong");

  // While debug owns port D pin 2 it is never driven.
  a_debug_clock: assert property (!s.dbg_rel ##1 !s.dbg_rel |-> !s.pad[3].oe[2]) // RULE_09
    else $error("debug clock pin driven");

  // The trigger select holds while port C pin 3 interrupt is enabled.
  a_nmi_sel_guard: assert property (int_en[2][3] |=> s.nmi_sel == $past(s.nmi_sel)) // RULE_12
    else $error("trigger select changed while pin interrupt enabled");

  // A set flag stays until a clear without a new event.
  a_flag_sticky: assert property (s.flag[1] && !clr[1] |=> s.flag[1]) // RULE_16
    else $error("port flag dropped without clear");

  // A clear with no new event empties the flag.
  a_flag_clear: assert property (clr[0] && !set[0] |=> !s.flag[0]) // RULE_13
    else $error("port flag not cleared");

  // A rising edge on an enabled port A pin in rising mode sets the flag.
  a_rise_flag: assert property (s.trig[1:0] == TRIG_RISE && int_en[0][0] && rise[0][0]
    |=> s.flag[0]) // RULE_15
    else $error("rising edge did not set port flag");

  // Interrupt output follows the unmasked flags.
  a_irq_mask: assert property (s.flag[2] && s.mask[2] |-> irq) // RULE_16
    else $error("unmasked flag did not raise interrupt");

  c_write: cover property (do_wr && wr_hit);
  c_port_flag: cover property (!s.flag[3] ##1 s.flag[3]);
  c_nmi_flag: cover property (!s.flag[NMI_FLAG] ##1 s.flag[NMI_FLAG]);
  c_debug_release: cover property (!s.dbg_rel ##1 s.dbg_rel);

endmodule

// >>> gio_pins_model.sv
// Model of the package pins and the board drivers around the GPIO block.
`timescale 1ns/1ps

module gio_pins_model
(
  // Clock.
  input wire logic clk_sys,
  // Pad drive from the block.
  input wire gio_pkg::gio_pad_type [3:0] pad,
  // Board drivers.
  input wire logic [3:0][7:0] ext_en,
  input wire logic [3:0][7:0] ext_val,
  // Resolved pin levels.
  output logic [3:0][7:0] pin_in
);
  import gio_pkg::*;
  logic [7:0] drift = 8'h5a;

  // A floating pin changes level every cycle, so no stale value can pass for a real one.
  always @(posedge clk_sys)
    drift <= ~drift;

  // Block drive wins, then the board, then the pull-up, else the drifting level.
  always_comb
  begin
    for (int p = 0; p < 4; p++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        pin_in[p][i] = pad[p].oe[i] ? pad[p].out[i] : ext_en[p][i] ? ext_val[p][i] :
          pad[p].pull_up[i] ? 1'h1 : drift[i];
      end
    end
  end
endmodule

// >>> gio_port_with_ext_irq_bench.sv
// Self-checking bench of the GPIO block against a register model and a pins model.
`timescale 1ns/1ps

module gio_port_with_ext_irq_bench;
  import gio_pkg::*;
  // ==========================================================================
  // Signals
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq_nmi, irq, dbg_swdio_in, dbg_swclk_in;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d, v;
  logic [3:0] irq_port;
  logic [3:0][7:0] pin_in, alt_en = 32'h0, alt_out = 32'h0, ext_en = 32'h0, ext_val = 32'h0;
  logic dbg_swdio_out = 1'h0, dbg_swdio_oe = 1'h0, nmi_route = 1'h0;
  gio_pad_type [3:0] pad;
  logic [31:0] mdl [int];
  logic [11:0] glb [4] = '{12'h100, 12'h200, 12'h204, 12'h20c};
  integer seed = 32'hc007;
  int fails = 0;
  int cmp_count = 0;

  // Clock of 10 ns.
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Block under test and its pins.
  gio_port i_gio_port (.clk_sys, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .pin_in, .pad, .alt_en, .alt_out, .dbg_swdio_out, .dbg_swdio_oe, .dbg_swdio_in,
    .dbg_swclk_in, .nmi_route, .irq_port, .irq_nmi, .irq);
  gio_pins_model i_gio_pins_model (.clk_sys, .pad, .ext_en, .ext_val, .pin_in);

  // ==========================================================================
  // Checking and register model
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tmo(input bit ok);
    if (!ok)
    begin
      fails++;
      $display("unexpected bus wait: expected answer seen none");
      tally_and_finish;
    end
  endtask

  // Writable bits of each register; zero where nothing may be written.
  function automatic logic [31:0] wmask(input logic [11:0] a);
    if (a < 12'h080 && a[4:0] inside {5'h00, 5'h08, 5'h0c, 5'h10})
      return 32'hff;
    case (a)
      12'h100: return 32'h1;
      12'h200: return 32'hff;
      12'h204: return 32'h4;
      12'h20c: return 32'h4f;
      default: return 32'h0;
    endcase
  endfunction

  function automatic logic [1:0] xresp(input logic [11:0] a);
    if (wmask(a) != 32'h0 || a == 12'h208 || (a < 12'h080 && a[4:0] == 5'h04))
      return RESP_OKAY;
    return RESP_SLVERR;
  endfunction

  // ==========================================================================
  // Bus master
  task automatic wr(input logic [11:0] a, input logic [31:0] dv, input logic [3:0] s = 4'hf);
    logic ha, hw, hb;
    logic [1:0] r;
    hb = 1'h0;
    @(posedge clk_sys);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= dv;
    wstrb <= s;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 64 && !hb; n++)
    begin
      @(negedge clk_sys);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r = bresp;
      @(posedge clk_sys);
      if (ha)
        awvalid <= 1'h0;
      if (hw)
        wvalid <= 1'h0;
    end
    bready <= 1'h0;
    tmo(hb);
    chk(r, xresp(a), "write response");
    if (wmask(a) != 32'h0 && s[0] && !(a == 12'h204 && !mdl[12'h048][3] && mdl[12'h050][3]))
      mdl[a] = dv & wmask(a);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] dv);
    logic ha, hr;
    logic [1:0] r;
    hr = 1'h0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 64 && !hr; n++)
    begin
      @(negedge clk_sys);
      ha = arvalid && arready;
      hr = rvalid;
      dv = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ha)
        arvalid <= 1'h0;
    end
    rready <= 1'h0;
    tmo(hr);
    chk(r, xresp(a), "read response");
  endtask

  task automatic rdm(input logic [11:0] a);
    logic [31:0] dv;
    rd(a, dv);
    chk(dv, mdl.exists(a) ? mdl[a] : 32'h0, "register");
  endtask

  // Moves one pin, lets the filter settle, clears flags if asked and reads them back.
  task automatic ev(input int p, input int i, input logic lv, input logic [6:0] cl,
    input logic [6:0] ex);
    logic [31:0] fv;
    ext_val[p][i] <= lv;
    repeat (6) @(posedge clk_sys);
    if (cl != 7'h0)
      wr(12'h208, 32'(cl));
    rd(12'h208, fv);
    chk(fv, 32'(ex), "flag status");
  endtask

  // ==========================================================================
  // Scenarios
  initial
  begin
    mdl[12'h06c] = 32'h2;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'h1;
    // Reset values of every register except the input and clear registers.
    for (int p = 0; p < 4; p++)
      for (int k = 0; k < 5; k++)
        if (k != 1)
          rdm(12'(p * 32 + k * 4));
    foreach (glb[k])
      rdm(glb[k]);
    chk(pad[3].pull_up, 32'h2, "reset pull-up");
    chk(irq, 32'h0, "reset interrupt");
    // Outputs, drive mode and speed on all ports; debug owns port D pins 1 and 2.
    for (int p = 0; p < 4; p++)
    begin
      d = $random(seed);
      wr(12'(p * 32), d);
      wr(12'(p * 32 + 8), 32'hff);
      wr(12'(p * 32 + 12), 32'hff);
      wr(12'(p * 32 + 16), d >> 8);
      repeat (2) @(posedge clk_sys);
      v = (p == 3) ? 32'hf9 : 32'hff;
      chk(pad[p].out & v, d & v, "pad level");
      chk(pad[p].oe & v, v, "pad drive");
      chk(pad[p].fast & v, d[15:8] & v, "pad speed");
    end
    dbg_swdio_oe <= 1'h1;
    dbg_swdio_out <= 1'($random(seed));
    ext_en[3][2] <= 1'h1;
    ext_val[3][2] <= 1'($random(seed));
    repeat (6) @(posedge clk_sys);
    chk(pad[3].oe[2:1], 32'h1, "debug drive");
    chk(pad[3].out[1], dbg_swdio_out, "debug data");
    chk(dbg_swdio_in, dbg_swdio_out, "debug data in");
    chk(dbg_swclk_in, ext_val[3][2], "debug clock");
    wr(12'h100, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(pad[3].out, mdl[12'h060], "released level");
    chk(pad[3].oe, 32'hff, "released drive");
    // Open drain with alternate functions on port A.
    wr(12'h00c, 32'h0);
    alt_en[0] <= 8'($random(seed));
    alt_out[0] <= 8'($random(seed));
    repeat (3) @(posedge clk_sys);
    v = (alt_en[0] & alt_out[0]) | (~alt_en[0] & mdl[12'h000][7:0]);
    chk(pad[0].oe, 32'(8'(~v)), "open drain");
    chk(pad[0].out, 32'h0, "open drain level");
    // Inputs: board drive on port B, pull-ups on port A, interrupts off.
    alt_en[0] <= 8'h0;
    for (int p = 0; p < 4; p++)
    begin
      wr(12'(p * 32 + 8), 32'h0);
      wr(12'(p * 32 + 16), 32'h0);
    end
    wr(12'h00c, 32'hff);
    ext_en[1] <= 8'hff;
    ext_val[1] <= 8'($random(seed));
    repeat (6) @(posedge clk_sys);
    rd(12'h024, d);
    chk(d, ext_val[1], "input level");
    rd(12'h004, d);
    chk(d, 32'hff, "pull-up level");
    // Every trigger mode on port B pin 0, level mode re-setting after a clear.
    wr(12'h030, 32'h1);
    wr(12'h20c, 32'h2);
    for (int m = 0; m < 4; m++)
    begin
      wr(12'h200, 32'(m << 2));
      ev(1, 0, 1'h1, 7'h4f, 7'h0);
      ev(1, 0, 1'h0, 7'h0, {5'h0, m != 1, 1'h0});
      chk(irq, m != 1, "masked interrupt");
      ev(1, 0, 1'h0, 7'h4f, {5'h0, m == 0, 1'h0});
      ev(1, 0, 1'h1, 7'h0, {5'h0, m != 2, 1'h0});
      chk(irq_port, {2'h0, m != 2, 1'h0}, "port flags");
    end
    wr(12'h20c, 32'h0);
    chk(irq, 32'h0, "masked off");
    // Non-maskable line on port C pin 3.
    nmi_route <= 1'h1;
    ext_en[2][3] <= 1'h1;
    ext_val[2][3] <= 1'h0;
    wr(12'h050, 32'h8);
    wr(12'h204, 32'h4);
    rdm(12'h204);
    wr(12'h050, 32'h0);
    wr(12'h204, 32'h4);
    rdm(12'h204);
    wr(12'h050, 32'h8);
    ev(2, 3, 1'h0, 7'h4f, 7'h0);
    ev(2, 3, 1'h1, 7'h0, 7'h40);
    chk({irq_nmi, irq_port[2]}, 32'h2, "nmi outputs");
    ev(2, 3, 1'h0, 7'h40, 7'h0);
    // Without the route, port C pin 3 feeds the port C flag and its low level re-sets it.
    nmi_route <= 1'h0;
    ev(2, 3, 1'h0, 7'h4f, 7'h04);
    // Unmapped places, reserved bits and a write without its low byte lane.
    wr(12'h014, 32'hff);
    rdm(12'h014);
    wr(12'h300, 32'h1);
    rdm(12'h300);
    wr(12'h008, 32'hffffffff);
    rdm(12'h008);
    wr(12'h000, 32'h5a, 4'he);
    rdm(12'h000);
    tally_and_finish;
  end
endmodule
